// *** hw/eeo_cmd_decode.sv ***
// Decodes A/B, step/direction or up/down command pulses into a position
`timescale 1ns/1ps
`default_nettype none
module eeo_cmd_decode
   import eeo_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Synchronised input pair and control
   input wire logic in_a,
   input wire logic in_b,
   input wire logic enable,
   input wire logic [1:0] format,
   // Command position
   output logic [31:0] cmd_pos
);
   logic a_reg;
   logic b_reg;
   logic up;
   logic down;
   logic ab_chg;
   // Quadrature: direction from old A xor new B
   assign ab_chg = (in_a != a_reg) || (in_b != b_reg);
   assign up = (format == EEO_FMT_AB) ? (ab_chg && (a_reg ^ in_b)) :
      (format == EEO_FMT_SD) ? (in_a && !a_reg && !in_b) :
      (format == EEO_FMT_UD) ? (in_a && !a_reg) : 1'b0;
   assign down = (format == EEO_FMT_AB) ? (ab_chg && !(a_reg ^ in_b)) :
      (format == EEO_FMT_SD) ? (in_a && !a_reg && in_b) :
      (format == EEO_FMT_UD) ? (in_b && !b_reg) : 1'b0;

   // Count only while enabled; otherwise just track edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
         cmd_pos <= '0;
      end else begin
         a_reg <= in_a;
         b_reg <= in_b;
         if (enable && up && !down) begin
            cmd_pos <= cmd_pos + 32'h0000_0001;
         end else if (enable && down && !up) begin
            cmd_pos <= cmd_pos - 32'h0000_0001;
         end
      end
   end
endmodule
`default_nettype wire

// *** hw/eeo_pkg.sv ***
// Package of constants for the encoder emulation output block
package eeo_pkg;
   // Register offsets (word index on the plain register port)
   localparam logic [3:0] EEO_OFS_MODE = 4'h0;
   localparam logic [3:0] EEO_OFS_RES = 4'h1;
   localparam logic [3:0] EEO_OFS_ZOFS = 4'h2;
   localparam logic [3:0] EEO_OFS_TURNS = 4'h3;
   localparam logic [3:0] EEO_OFS_FB2 = 4'h4;
   localparam logic [3:0] EEO_OFS_FULL = 4'h5;
   localparam logic [3:0] EEO_OFS_OUTPOS = 4'h6;
   localparam logic [3:0] EEO_OFS_CMDPOS = 4'h7;
   localparam logic [3:0] EEO_OFS_STATUS = 4'h8;
   // Field positions in the secondary feedback register
   localparam int EEO_FB2_FMT_LSB = 0;
   localparam int EEO_FB2_SRC_LSB = 4;
   localparam int EEO_FB2_DIR_BIT = 8;
   // Reset values
   localparam logic [3:0] EEO_MODE_RST = 4'h0;
   localparam logic [31:0] EEO_RES_RST = 32'h0000_0000;
   localparam logic [15:0] EEO_ZOFS_RST = 16'h0000;
   localparam logic [15:0] EEO_TURNS_RST = 16'h0000;
   // Fixed index offset scale: one revolution = 65536 units
   localparam int EEO_REV_BITS = 16;
   // Emulation modes
   localparam logic [3:0] EEO_MODE_INPUT = 4'h0;
   localparam logic [3:0] EEO_MODE_AB_REV = 4'h1;
   localparam logic [3:0] EEO_MODE_AB_ABS = 4'h2;
   localparam logic [3:0] EEO_MODE_SD_REV = 4'h6;
   localparam logic [3:0] EEO_MODE_SD_ABS = 4'h7;
   // Secondary source and format codes
   localparam logic [1:0] EEO_SRC_NONE = 2'h0;
   localparam logic [1:0] EEO_SRC_CONN = 2'h1;
   localparam logic [1:0] EEO_SRC_OPTO = 2'h2;
   localparam logic [1:0] EEO_FMT_AB = 2'h0;
   localparam logic [1:0] EEO_FMT_SD = 2'h1;
   localparam logic [1:0] EEO_FMT_UD = 2'h2;
   // Least spacing between output counts, in ns, and its cycle count
   localparam int EEO_CLK_NS = 10;
   localparam int EEO_STEP_NS = 40;
   localparam int EEO_STEP_CYC = (EEO_STEP_NS + EEO_CLK_NS - 1) / EEO_CLK_NS;
   // Output pulse generator states
   typedef enum logic [2:0] {
      EEO_ST_IDLE = 3'b001,
      EEO_ST_SET = 3'b010,
      EEO_ST_HOLD = 3'b100
   } eeo_state_t;
endpackage

// *** hw/eeo_rate_div.sv ***
// Scales motor position to emulated counts with an exact per-rev total
`timescale 1ns/1ps
`default_nettype none
module eeo_rate_div
   import eeo_pkg::*;
#(
   parameter int POS_BITS = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Motor position, 16-bit fraction per turn
   input wire logic [POS_BITS-1:0] motor_pos,
   input wire logic [31:0] counts_per_rev,
   // Target count in emulated units
   output logic [POS_BITS-1:0] target_count
);
   // Turn part scales exactly; fraction uses a product then drops 16 bits
   logic [POS_BITS-1:0] turn_cnt;
   logic [47:0] frac_prod;
   logic [POS_BITS-1:0] next_val;
   assign turn_cnt = POS_BITS'($signed(motor_pos) >>> EEO_REV_BITS); // Sign kept going back
   assign frac_prod = 48'(motor_pos[EEO_REV_BITS-1:0]) * 48'(counts_per_rev);
   assign next_val = POS_BITS'(turn_cnt * counts_per_rev) +
      POS_BITS'(frac_prod >> EEO_REV_BITS);

   // Registered so the multiplier is off the pulse generator path
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         target_count <= '0;
      end else begin
         target_count <= next_val;
      end
   end
endmodule
`default_nettype wire

// *** hw/eeo_top.sv ***
// Encoder emulation output: A/B or step/dir with index, or command input
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Mode 0 drives no outputs; connector becomes an input in chosen format.
// - A/B modes drive A, B and index, A and B ninety degrees apart.
// - Every output count follows measured primary motor position.
// - Exactly the resolution setting of counts per primary revolution.
// - Mode 1 gives one index per turn at the offset fraction.
// - Index offset scale is 65536 units per revolution.
// - Offset scale ignores the output resolution setting.
// - Mode 2 gives index only where position equals the full offset.
// - Full offset is turns plus fractional index offset.
// - Full offset is readable only; writes do not change it.
// - Mode 6 gives step/direction with per-turn index; opto input accepted.
// - Mode 7 is mode 6 with a single absolute index.
// - Index placement in 6 follows mode 1, in 7 follows mode 2.
// - Source select: 0 none, 1 emulation connector, 2 opto connector.
// - Format select: 0 A/B, 1 step/direction, 2 up/down.
// - Connector as input turns command pulses into commanded position.
// - Direction setting chooses which rotation counts up.
// - Resolution counts quadrature edges, four per A/B cycle.
// - Zero resolution gives no command from the connector.
module eeo_top
   import eeo_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Primary feedback position, 16-bit fraction per turn
   input wire logic [31:0] motor_pos,
   // Emulation connector, three two-way channels
   input wire logic conn_a_in,
   input wire logic conn_b_in,
   input wire logic conn_z_in,
   output logic conn_a_out,
   output logic conn_b_out,
   output logic conn_z_out,
   output logic conn_oe_n,
   // Opto input connector pair
   input wire logic opto_a_in,
   input wire logic opto_b_in,
   // Secondary command position
   output logic [31:0] sec_cmd_pos
);
   // Control registers
   logic [3:0] emulation_mode_select_reg;
   logic [31:0] emulation_count_resolution_reg;
   logic [15:0] index_position_offset_reg;
   logic [15:0] absolute_index_turns_reg;
   logic [1:0] secondary_input_format_reg;
   logic [1:0] sec_source_reg;
   logic dir_invert_reg;
   logic [31:0] rdata_next;

   // Pin synchronisers, two stages before any use
   logic [4:0] pin_s1_reg;
   logic [4:0] pin_s2_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end else begin
         pin_s1_reg <= {opto_b_in, opto_a_in, conn_z_in, conn_b_in, conn_a_in};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // Mode decode
   wire out_mode = (emulation_mode_select_reg == EEO_MODE_AB_REV) ||
      (emulation_mode_select_reg == EEO_MODE_AB_ABS) ||
      (emulation_mode_select_reg == EEO_MODE_SD_REV) ||
      (emulation_mode_select_reg == EEO_MODE_SD_ABS);
   wire sd_mode = (emulation_mode_select_reg == EEO_MODE_SD_REV) ||
      (emulation_mode_select_reg == EEO_MODE_SD_ABS);
   wire abs_mode = (emulation_mode_select_reg == EEO_MODE_AB_ABS) ||
      (emulation_mode_select_reg == EEO_MODE_SD_ABS);
   // Full offset: whole turns above, turn fraction below
   wire [31:0] full_offset = {absolute_index_turns_reg, index_position_offset_reg};

   // Position mirrored by direction setting
   wire [31:0] pos_dir = dir_invert_reg ? (32'h0000_0000 - motor_pos) : motor_pos;

   // Scaled target count
   logic [31:0] target_count;
   eeo_rate_div #(
      .POS_BITS(32)
   ) u_div (
      .clk(clk),
      .rst(rst),
      .motor_pos(pos_dir),
      .counts_per_rev(emulation_count_resolution_reg),
      .target_count(target_count)
   );

   // Second-stage taps only; the first stage may still be metastable
   wire conn_a_sync = pin_s2_reg[0];
   wire conn_b_sync = pin_s2_reg[1];
   wire opto_a_sync = pin_s2_reg[3];
   wire opto_b_sync = pin_s2_reg[4];

   // Connector commands only in mode 0 and with a non-zero resolution
   wire conn_cmd_en = (emulation_mode_select_reg == EEO_MODE_INPUT) &&
      (emulation_count_resolution_reg != 32'h0000_0000) &&
      (sec_source_reg == EEO_SRC_CONN);
   // Handwheel counts when chosen as source, or beside step output
   wire opto_cmd_en = (sec_source_reg == EEO_SRC_OPTO) || sd_mode;
   wire sec_en = conn_cmd_en || opto_cmd_en;
   wire sec_a = opto_cmd_en ? opto_a_sync : conn_a_sync;
   wire sec_b = opto_cmd_en ? opto_b_sync : conn_b_sync;
   // Step output modes read the handwheel as step and direction
   wire [1:0] dec_format = sd_mode ? EEO_FMT_SD : secondary_input_format_reg;

   // Command decoder shared by connector and handwheel
   logic [31:0] cmd_pos;
   eeo_cmd_decode u_dec (
      .clk(clk),
      .rst(rst),
      .in_a(sec_a),
      .in_b(sec_b),
      .enable(sec_en),
      .format(dec_format),
      .cmd_pos(cmd_pos)
   );

   // Output pulse generator: one count per step, spacing held off
   eeo_state_t state_reg;
   eeo_state_t state_next;
   logic [31:0] out_count_reg;
   logic [7:0] hold_reg;
   logic [1:0] quad_reg;
   logic step_reg;
   logic dirout_reg;
   logic index_reg;

   // Signed distance, so travel either way is seen
   wire behind = $signed(target_count - out_count_reg) > 0;
   wire ahead = $signed(target_count - out_count_reg) < 0;
   wire move = behind || ahead;

   // Next state: one IDLE-SET-HOLD pass per count
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         EEO_ST_IDLE: begin
            if (out_mode && move) begin
               state_next = EEO_ST_SET;
            end
         end
         EEO_ST_SET: state_next = EEO_ST_HOLD;
         EEO_ST_HOLD: begin
            if (hold_reg == 8'h00) begin
               state_next = EEO_ST_IDLE;
            end
         end
         default: state_next = EEO_ST_IDLE;
      endcase
   end

   // Gray step per count keeps A and B in quadrature
   function automatic logic [1:0] eeo_gray_step(input logic [1:0] q, input logic up);
      logic [1:0] r;
      // Up: A moves first; down: B moves first
      r = up ? {~q[0], q[1]} : {q[0], ~q[1]};
      return r;
   endfunction

   // Index position in emulated units; mode 1/6 per turn, 2/7 absolute
   logic [31:0] rev_index_cnt;
   logic [31:0] abs_index_cnt;
   wire [47:0] zprod = 48'(index_position_offset_reg) * 48'(emulation_count_resolution_reg);
   wire [31:0] zfrac = 32'(zprod >> EEO_REV_BITS);
   assign abs_index_cnt = 32'(absolute_index_turns_reg) * emulation_count_resolution_reg +
      zfrac;
   assign rev_index_cnt = zfrac;
   // Signed remainder, so the per-turn index stays put below count zero
   logic [32:0] rem_s;
   assign rem_s = 33'($signed({out_count_reg[31], out_count_reg}) %
      $signed({1'b0, emulation_count_resolution_reg}));
   wire [31:0] in_rev = (emulation_count_resolution_reg == 32'h0000_0000) ? 32'h0000_0000 :
      rem_s[32] ? rem_s[31:0] + emulation_count_resolution_reg : rem_s[31:0];
   // Modes 2/7 compare the whole count; 1/6 only the part within a turn
   wire hit = abs_mode ? (out_count_reg == abs_index_cnt) : (in_rev == rev_index_cnt);

   // Count, phase and step pulse; hold keeps the least spacing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= EEO_ST_IDLE;
         out_count_reg <= '0;
         hold_reg <= '0;
         quad_reg <= 2'b00;
         step_reg <= 1'b0;
         dirout_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg == EEO_ST_IDLE && out_mode && move) begin
            // One post-quadrature edge per count
            out_count_reg <= behind ? out_count_reg + 32'h0000_0001 :
               out_count_reg - 32'h0000_0001;
            quad_reg <= eeo_gray_step(quad_reg, behind);
            step_reg <= 1'b1;
            dirout_reg <= ahead;
            hold_reg <= 8'(EEO_STEP_CYC);
         end else if (!out_mode) begin
            // Follow silently so switching on emits no burst
            out_count_reg <= target_count;
         end else if (hold_reg != 8'h00) begin
            hold_reg <= hold_reg - 8'h01;
            if (hold_reg == 8'(EEO_STEP_CYC / 2 + 1)) begin
               step_reg <= 1'b0;
            end
         end else begin
            step_reg <= 1'b0;
         end
      end
   end

   // Outputs registered; mode 0 releases the connector
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         index_reg <= 1'b0;
         conn_a_out <= 1'b0;
         conn_b_out <= 1'b0;
         conn_z_out <= 1'b0;
         conn_oe_n <= 1'b1;
         sec_cmd_pos <= '0;
      end else begin
         // Index is a level for as long as the count sits on it
         index_reg <= out_mode && hit;
         conn_oe_n <= !out_mode;
         // Step/direction modes reuse A for step and B for direction
         conn_a_out <= out_mode && (sd_mode ? step_reg : quad_reg[1]);
         conn_b_out <= out_mode && (sd_mode ? dirout_reg : quad_reg[0]);
         conn_z_out <= index_reg;
         sec_cmd_pos <= cmd_pos;
      end
   end

   // Register writes; full offset and status have no write path
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         emulation_mode_select_reg <= EEO_MODE_RST;
         emulation_count_resolution_reg <= EEO_RES_RST;
         index_position_offset_reg <= EEO_ZOFS_RST;
         absolute_index_turns_reg <= EEO_TURNS_RST;
         secondary_input_format_reg <= EEO_FMT_AB;
         sec_source_reg <= EEO_SRC_NONE;
         dir_invert_reg <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            // Unknown mode codes are kept but drive nothing
            EEO_OFS_MODE: emulation_mode_select_reg <= reg_wdata[3:0];
            EEO_OFS_RES: emulation_count_resolution_reg <= reg_wdata;
            EEO_OFS_ZOFS: index_position_offset_reg <= reg_wdata[15:0];
            EEO_OFS_TURNS: absolute_index_turns_reg <= reg_wdata[15:0];
            // Format, source and direction share one word
            EEO_OFS_FB2: begin
               secondary_input_format_reg <= reg_wdata[EEO_FB2_FMT_LSB +: 2];
               sec_source_reg <= reg_wdata[EEO_FB2_SRC_LSB +: 2];
               dir_invert_reg <= reg_wdata[EEO_FB2_DIR_BIT];
            end
            default: ;
         endcase
      end
   end

   // Read mux, registered for one-cycle-later data
   always_comb begin
      case (reg_addr)
         EEO_OFS_MODE: rdata_next = {28'h0, emulation_mode_select_reg};
         EEO_OFS_RES: rdata_next = emulation_count_resolution_reg;
         EEO_OFS_ZOFS: rdata_next = {16'h0, index_position_offset_reg};
         EEO_OFS_TURNS: rdata_next = {16'h0, absolute_index_turns_reg};
         EEO_OFS_FB2: rdata_next = {23'h0, dir_invert_reg, 2'h0, sec_source_reg,
            2'h0, secondary_input_format_reg};
         EEO_OFS_FULL: rdata_next = full_offset;
         EEO_OFS_OUTPOS: rdata_next = out_count_reg;
         EEO_OFS_CMDPOS: rdata_next = cmd_pos;
         EEO_OFS_STATUS: rdata_next = {27'h0, index_reg, sec_en, out_mode, quad_reg};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // Data stands one cycle, zero otherwise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// *** verif/eeo_far_model.sv ***
// Far-side controller: follows emulated pulses, can send command pulses
`timescale 1ns/1ps
`default_nettype none
module eeo_far_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins seen and driven
   input wire logic step_mode,
   input wire logic pin_a,
   input wire logic pin_b,
   input wire logic pin_z,
   output logic drv_a = 1'b0,
   output logic drv_b = 1'b0
);
   int count;
   int index_cnt;
   logic a_q, b_q, z_q;
   // Position command: edge rate is velocity, sign is direction
   always @(posedge clk) begin
      if (rst) begin
         count <= 0;
         index_cnt <= 0;
         {a_q, b_q, z_q} <= 3'h0;
      end else begin
         {a_q, b_q, z_q} <= {pin_a, pin_b, pin_z};
         if (pin_z && !z_q) index_cnt <= index_cnt + 1;
         if (step_mode && pin_a && !a_q) count <= pin_b ? count - 1 : count + 1;
         else if (!step_mode && (pin_a ^ a_q ^ pin_b ^ b_q)) count <= (pin_a ^ b_q) ? count + 1 : count - 1;
      end
   end
   // Forward pulses, 4 cycles apart so the two-flop sync sees each level
   task automatic send(input int n, input int fmt);
      repeat (n) begin
         if (fmt == 0) begin
            if (drv_a == drv_b) drv_a <= !drv_a;
            else drv_b <= !drv_b;
         end else begin
            drv_a <= 1'b1;
            repeat (4) @(posedge clk);
            drv_a <= 1'b0;
         end
         repeat (4) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// *** verif/eeo_props.sv ***
// Port checker for the encoder emulation output block
`timescale 1ns/1ps
`default_nettype none
module eeo_props
   import eeo_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Connector and command
   input wire logic conn_a_out,
   input wire logic conn_b_out,
   input wire logic conn_z_out,
   input wire logic conn_oe_n,
   input wire logic [31:0] sec_cmd_pos
);
   logic [3:0] mode_q;
   logic [15:0] zofs_q;
   logic [15:0] turns_q;
   logic res_z;
   logic opto_q;
   logic [2:0] quiet;
   wire logic is_ab = mode_q == EEO_MODE_AB_REV || mode_q == EEO_MODE_AB_ABS;
   wire logic is_sd = mode_q == EEO_MODE_SD_REV || mode_q == EEO_MODE_SD_ABS;
   // Shadow of settings; quiet counts cycles since the last write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q <= EEO_MODE_RST;
         zofs_q <= EEO_ZOFS_RST;
         turns_q <= EEO_TURNS_RST;
         res_z <= 1'b1;
         opto_q <= 1'b0;
         quiet <= 3'h0;
      end else begin
         if (reg_wr && reg_addr == EEO_OFS_MODE) mode_q <= reg_wdata[3:0];
         if (reg_wr && reg_addr == EEO_OFS_ZOFS) zofs_q <= reg_wdata[15:0];
         if (reg_wr && reg_addr == EEO_OFS_TURNS) turns_q <= reg_wdata[15:0];
         if (reg_wr && reg_addr == EEO_OFS_RES) res_z <= reg_wdata == 32'h0;
         if (reg_wr && reg_addr == EEO_OFS_FB2) opto_q <= reg_wdata[5:4] == EEO_SRC_OPTO;
         quiet <= reg_wr ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_reset_state: assert property ($fell(rst) |-> conn_oe_n && !conn_z_out && reg_rdata == 32'h0)
      else $error("outputs not at reset values");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside a read");
   a_full_offset: assert property ($past(reg_rd && reg_addr == EEO_OFS_FULL) |-> reg_rdata == {turns_q, zofs_q})
      else $error("full offset read wrong");
   a_drive_by_mode: assert property (quiet == 3'h7 |-> conn_oe_n == !(is_ab || is_sd))
      else $error("drive enable does not match mode");
   a_ab_gray: assert property (quiet == 3'h7 && is_ab |-> !($changed(conn_a_out) && $changed(conn_b_out)))
      else $error("A and B changed together");
   a_level_holds: assert property ($changed(conn_a_out) && !conn_oe_n |=> $stable(conn_a_out))
      else $error("output level held one cycle only");
   a_dir_holds: assert property (quiet == 3'h7 && is_sd && $rose(conn_a_out) |=> $stable(conn_b_out))
      else $error("direction moved during step");
   a_no_cmd_zero: assert property (quiet == 3'h7 && res_z && !opto_q && !is_sd |=> $stable(sec_cmd_pos))
      else $error("command moved with zero resolution");
endmodule
bind eeo_top eeo_props chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .conn_a_out, .conn_b_out, .conn_z_out, .conn_oe_n, .sec_cmd_pos);
`default_nettype wire

// *** verif/encoder_emulation_output_bench.sv ***
// Self-checking bench for the encoder emulation output block
`timescale 1ns/1ps
`default_nettype none
module encoder_emulation_output_bench;
   import eeo_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] motor_pos = 32'h0;
   logic step_mode = 1'b0;
   wire logic [31:0] reg_rdata, sec_cmd_pos;
   wire logic a_out, b_out, z_out, oe_n, m_a, m_b;
   int error_cnt = 0;
   int n_tests = 0;
   // Pin level: the device when enabled, else the far side
   wire logic a_pin = oe_n ? m_a : a_out;
   wire logic b_pin = oe_n ? m_b : b_out;
   wire logic z_pin = oe_n ? 1'b0 : z_out;
   always #5 clk = ~clk;
   eeo_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_pos(motor_pos),
      .conn_a_in(a_pin), .conn_b_in(b_pin), .conn_z_in(z_pin), .conn_a_out(a_out),
      .conn_b_out(b_out), .conn_z_out(z_out), .conn_oe_n(oe_n), .opto_a_in(m_a),
      .opto_b_in(m_b), .sec_cmd_pos(sec_cmd_pos));
   eeo_far_model far (.clk(clk), .rst(rst), .step_mode(step_mode), .pin_a(a_pin),
      .pin_b(b_pin), .pin_z(z_pin), .drv_a(m_a), .drv_b(m_b));
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   // Data stands one cycle only, so it is sampled just after the edge
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("read data", exp, reg_rdata);
      @(posedge clk);
   endtask
   task automatic settle();
      repeat (400) @(posedge clk);
   endtask
   // One step is 1/64 turn; 8 cycles apart stays under the output rate
   task automatic move(input int steps);
      repeat (steps) begin
         motor_pos <= motor_pos + 32'h400;
         repeat (8) @(posedge clk);
      end
      settle();
   endtask
   task automatic t_regs();
      for (int i = 0; i < 5; i++) rd(i[3:0], 32'h0);
      wr(EEO_OFS_TURNS, 32'h3);
      wr(EEO_OFS_ZOFS, 32'h8000);
      wr(EEO_OFS_FULL, 32'hffff_ffff);
      wr(4'hf, 32'hffff_ffff);
      rd(EEO_OFS_FULL, 32'h0003_8000);
      rd(4'hf, 32'h0);
   endtask
   task automatic t_index(input logic [3:0] md, input logic [15:0] tn, input int revs, input logic sd);
      int c0;
      int z0;
      wr(EEO_OFS_TURNS, {16'h0, tn});
      wr(EEO_OFS_MODE, {28'h0, md});
      step_mode <= sd;
      settle();
      chk("drive enable", 32'h0, {31'h0, oe_n});
      c0 = far.count;
      z0 = far.index_cnt;
      move(revs * 64);
      chk("output counts", revs * 16, far.count - c0);
      chk("index pulses", 32'h1, far.index_cnt - z0);
   endtask
   task automatic t_invert();
      int c0;
      wr(EEO_OFS_FB2, 32'h100);
      settle();
      c0 = far.count;
      move(64);
      chk("inverted counts", 32'hffff_fff0, far.count - c0);
      wr(EEO_OFS_FB2, 32'h0);
      settle();
   endtask
   task automatic pulses(input int fmt, input logic [31:0] exp);
      logic [31:0] p0;
      logic [31:0] d;
      repeat (20) @(posedge clk);
      p0 = sec_cmd_pos;
      far.send(8, fmt);
      repeat (20) @(posedge clk);
      d = sec_cmd_pos - p0;
      chk("command travel", exp, d[31] ? -d : d);
   endtask
   task automatic t_input();
      wr(EEO_OFS_MODE, 32'h0);
      settle();
      chk("drive enable", 32'h1, {31'h0, oe_n});
      for (int f = 0; f < 3; f++) begin
         wr(EEO_OFS_FB2, 32'h10 + f);
         pulses(f, 32'h8);
      end
      wr(EEO_OFS_FB2, 32'h20);
      pulses(0, 32'h8);
      wr(EEO_OFS_RES, 32'h0);
      wr(EEO_OFS_FB2, 32'h10);
      pulses(0, 32'h0);
   endtask
   // Cut a hang short; the run needs about 10k cycles
   initial begin
      #400000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      wr(EEO_OFS_RES, 32'h10);
      t_index(EEO_MODE_AB_REV, 16'h0, 1, 1'b0);
      t_invert();
      t_index(EEO_MODE_AB_ABS, 16'h3, 3, 1'b0);
      t_index(EEO_MODE_SD_ABS, 16'h6, 3, 1'b1);
      t_index(EEO_MODE_SD_REV, 16'h0, 1, 1'b1);
      pulses(1, 32'h8);
      t_input();
      print_verdict();
   end
endmodule
`default_nettype wire
